// >>> mdh_top.sv
// module: two-axis move-done handshake with machine-control I/O timing
//
// Operation
// - digital I/O refreshed at 256 Hz, analog inputs sampled at 32 Hz.
// - each of the four analog inputs is held as an 8-bit value.
// - the strobe and user outputs are active low; MOVE_GO_O and HS_MODE_O are active high.
// - strobe asserts low on move completion, idle while moving.
// - handshake off gives a strobe pulse of up to 3.9 ms per move, ending on the next tick.
// - handshake off, pending move waits while busy is low at strobe end.
// - handshake on asserts strobe at once, samples busy 350 us later.
// - handshake on, busy inactive is resampled every 3.9 ms, no timeout.
// - handshake on, strobe drops on the next tick after busy seen active, at most 3.9 ms later.
// - handshake on, pending move starts only after busy releases.
// - digital inputs, busy included, are active low.
// - user outputs change only on 256 Hz ticks.
`timescale 1ns/1ps
module mdh_top
  import mdh_pkg::*;
#(
  parameter int unsigned TICK_DIV  = TICK_CYCLES,
  parameter int unsigned FIRST_DLY = FIRST_SAMPLE_CYCLES,
  parameter int unsigned NUM_OUT   = 2,
  parameter int unsigned NUM_IN    = 2
) (
  input  wire logic                          CLK_I,
  input  wire logic                          RESETN_I,
  input  wire logic                          CE_I,
  input  wire logic [N_AXES-1:0]             BUSY_N_I,
  input  wire logic                          X_HANDSHAKE_ON_CMD_I,
  input  wire logic                          X_HANDSHAKE_OFF_CMD_I,
  input  wire logic                          Y_HANDSHAKE_ON_CMD_I,
  input  wire logic                          Y_HANDSHAKE_OFF_CMD_I,
  input  wire logic [N_AXES-1:0]             MOVE_REQ_I,
  input  wire logic [N_AXES-1:0]             MOVE_DONE_I,
  input  wire logic [NUM_OUT-1:0]            USER_OUT_I,
  input  wire logic [NUM_IN-1:0]             USER_IN_N_I,
  input  wire logic [ANA_CH*ADC_BITS-1:0]    ANALOG_I,
  output logic      [N_AXES-1:0]             MOVE_DONE_STROBE_N_O,
  output logic      [N_AXES-1:0]             MOVE_GO_O,
  output logic      [N_AXES-1:0]             HS_MODE_O,
  output logic      [NUM_OUT-1:0]            USER_OUT_N_O,
  output logic      [NUM_IN-1:0]             USER_IN_O,
  output logic      [ANA_CH*ADC_BITS-1:0]    ANALOG_O
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [N_AXES-1:0] bsy_m_reg;
  logic [N_AXES-1:0] bsy_s_reg;
  logic [NUM_IN-1:0] uin_m_reg;
  logic [NUM_IN-1:0] uin_s_reg;
  logic [ANA_CH*ADC_BITS-1:0] ana_m_reg;
  logic [ANA_CH*ADC_BITS-1:0] ana_s_reg;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      bsy_m_reg <= '1;
      bsy_s_reg <= '1;
      uin_m_reg <= '1;
      uin_s_reg <= '1;
      ana_m_reg <= '0;
      ana_s_reg <= '0;
    end else if (CE_I) begin
      bsy_m_reg <= BUSY_N_I;
      bsy_s_reg <= bsy_m_reg;
      uin_m_reg <= USER_IN_N_I;
      uin_s_reg <= uin_m_reg;
      ana_m_reg <= ANALOG_I;
      ana_s_reg <= ana_m_reg;
    end
  end

  // ---------------------------------------------------------------
  // timebase
  // ---------------------------------------------------------------
  mdh_tick_if tk ();

  mdh_timebase #(
    .TICK_DIV (TICK_DIV)
  ) u_tb (
    .clk_i    (CLK_I),
    .resetn_i (RESETN_I),
    .ce_i     (CE_I),
    .tk       (tk.src)
  );

  // ---------------------------------------------------------------
  // busy sampled on ticks only: a glitch between ticks is not seen
  // ---------------------------------------------------------------
  logic [N_AXES-1:0] bsy_tick_reg;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      bsy_tick_reg <= '1;
    end else if (CE_I && tk.tick) begin
      bsy_tick_reg <= bsy_s_reg;
    end
  end

  // ---------------------------------------------------------------
  // axis sequencers
  // ---------------------------------------------------------------
  wire [N_AXES-1:0] hs_on  = {Y_HANDSHAKE_ON_CMD_I, X_HANDSHAKE_ON_CMD_I};
  wire [N_AXES-1:0] hs_off = {Y_HANDSHAKE_OFF_CMD_I, X_HANDSHAKE_OFF_CMD_I};

  genvar g;
  generate
    for (g = 0; g < N_AXES; g++) begin : g_axis
      // first sample after 350 us reads the live synchronised pin
      wire busy_view = bsy_s_reg[g] & bsy_tick_reg[g];

      mdh_axis #(
        .FIRST_DLY (FIRST_DLY)
      ) u_axis (
        .clk_i       (CLK_I),
        .resetn_i    (RESETN_I),
        .ce_i        (CE_I),
        .tk          (tk.dst),
        .busy_i      (busy_view),
        .hs_on_i     (hs_on[g]),
        .hs_off_i    (hs_off[g]),
        .move_req_i  (MOVE_REQ_I[g]),
        .move_done_i (MOVE_DONE_I[g]),
        .strobe_n_o  (MOVE_DONE_STROBE_N_O[g]),
        .move_go_o   (MOVE_GO_O[g]),
        .hs_mode_o   (HS_MODE_O[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // user I/O and analog capture
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      USER_OUT_N_O <= '1;
      USER_IN_O    <= '0;
      ANALOG_O     <= '0;
    end else if (CE_I) begin
      if (tk.tick) begin
        USER_OUT_N_O <= ~USER_OUT_I;
        USER_IN_O    <= ~uin_s_reg;
      end
      if (tk.ana_tick) begin
        ANALOG_O <= ana_s_reg;
      end
    end
  end
endmodule

// >>> mdh_pkg.sv
// package: constants and types for the move-done handshake block
package mdh_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_HZ         = 256;
  localparam int unsigned ANA_HZ          = 32;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / TICK_HZ;
  localparam int unsigned ANA_TICK_DIV    = TICK_HZ / ANA_HZ;
  localparam int unsigned FIRST_SAMPLE_US = 350;
  localparam int unsigned FIRST_SAMPLE_CYCLES =
    (FIRST_SAMPLE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned ADC_BITS        = 8;
  localparam int unsigned ANA_CH          = 4;
  localparam int unsigned N_AXES          = 2;
  localparam logic        OUT_ACTIVE      = 1'b0;
  localparam logic        OUT_IDLE        = 1'b1;
  localparam logic        HS_RESET        = 1'b0;

  typedef enum {
    MDH_IDLE,
    MDH_MOVING,
    MDH_PULSE,
    MDH_HOLD,
    MDH_FIRST,
    MDH_WAIT_ACK,
    MDH_DROP,
    MDH_WAIT_REL
  } mdh_state_e;

  function automatic logic mdh_active_low(input logic pin);
    return pin == 1'b0;
  endfunction
endpackage

// >>> mdh_tick_if.sv
// interface: timing strobes shared by the timebase and the axis logic
`timescale 1ns/1ps
interface mdh_tick_if;
  logic tick;
  logic ana_tick;
  modport src (output tick, output ana_tick);
  modport dst (input tick, input ana_tick);
endinterface

// >>> mdh_timebase.sv
// module: 256 Hz tick and 32 Hz analog tick from the system clock
`timescale 1ns/1ps
module mdh_timebase
  import mdh_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic ce_i,
  mdh_tick_if.src   tk
);
  logic [31:0] cnt_reg;
  logic [2:0]  ana_reg;
  wire         wrap = (cnt_reg == 32'(TICK_DIV - 1));

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_reg     <= '0;
      ana_reg     <= '0;
      tk.tick     <= 1'b0;
      tk.ana_tick <= 1'b0;
    end else if (ce_i) begin
      cnt_reg     <= wrap ? '0 : cnt_reg + 32'h1;
      tk.tick     <= wrap;
      tk.ana_tick <= wrap && (ana_reg == 3'(ANA_TICK_DIV - 1));
      if (wrap) begin
        ana_reg <= ana_reg + 3'h1;
      end
    end
  end
endmodule

// >>> mdh_axis.sv
// module: per-axis move-done strobe and busy handshake sequencer
`timescale 1ns/1ps
module mdh_axis
  import mdh_pkg::*;
#(
  parameter int unsigned FIRST_DLY = FIRST_SAMPLE_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic ce_i,
  mdh_tick_if.dst   tk,
  input  wire logic busy_i,
  input  wire logic hs_on_i,
  input  wire logic hs_off_i,
  input  wire logic move_req_i,
  input  wire logic move_done_i,
  output logic      strobe_n_o,
  output logic      move_go_o,
  output logic      hs_mode_o
);
  mdh_state_e  st_reg;
  mdh_state_e  st_next;
  logic [15:0] dly_reg;
  logic        pend_reg;
  wire         bsy = mdh_active_low(busy_i);
  wire         strobe_next = (st_next == MDH_PULSE) ||
                             (st_next == MDH_FIRST) ||
                             (st_next == MDH_WAIT_ACK) ||
                             (st_next == MDH_DROP);
  wire         go_next;

  assign go_next = (st_reg != MDH_MOVING) && (st_next == MDH_MOVING);

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      MDH_IDLE:
        if (pend_reg || move_req_i) st_next = MDH_MOVING;
      MDH_MOVING:
        if (move_done_i) begin
          st_next = hs_mode_o ? MDH_FIRST : MDH_PULSE;
        end
      MDH_PULSE:
        if (tk.tick) begin
          st_next = bsy ? MDH_HOLD : MDH_IDLE;
        end
      MDH_HOLD:
        if (tk.tick && !bsy) st_next = MDH_IDLE;
      MDH_FIRST:
        if (dly_reg == 16'(FIRST_DLY - 1)) begin
          st_next = bsy ? MDH_DROP : MDH_WAIT_ACK;
        end
      MDH_WAIT_ACK:
        if (tk.tick && bsy) st_next = MDH_DROP;
      MDH_DROP:
        if (tk.tick) st_next = MDH_WAIT_REL;
      MDH_WAIT_REL:
        if (tk.tick && !bsy) st_next = MDH_IDLE;
      default:
        st_next = MDH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_reg     <= MDH_IDLE;
      dly_reg    <= '0;
      pend_reg   <= 1'b0;
      strobe_n_o <= OUT_IDLE;
      move_go_o  <= 1'b0;
      hs_mode_o  <= HS_RESET;
    end else if (ce_i) begin
      st_reg     <= st_next;
      dly_reg    <= (st_reg == MDH_FIRST) ? dly_reg + 16'h1 : '0;
      // a request during a handshake waits here until release
      // a request that meets the go of an older one is kept, not lost
      pend_reg   <= go_next ? (pend_reg & move_req_i)
                            : (pend_reg | move_req_i);
      // strobe refreshed only on ticks except the immediate edges
      strobe_n_o <= strobe_next ? OUT_ACTIVE : OUT_IDLE;
      move_go_o  <= go_next;
      if (hs_on_i) begin
        hs_mode_o <= 1'b1;
      end else if (hs_off_i) begin
        hs_mode_o <= 1'b0;
      end
    end
  end
endmodule

// >>> mdh_top_monitor.sv
// checker: concurrent assertions on the move-done handshake top ports
`timescale 1ns/1ps
module mdh_top_monitor
  import mdh_pkg::*;
#(
  parameter int unsigned TICK_DIV = 10
) (
  input wire logic              CLK_I,
  input wire logic              RESETN_I,
  input wire logic              CE_I,
  input wire logic [N_AXES-1:0] BUSY_N_I,
  input wire logic              X_HANDSHAKE_ON_CMD_I,
  input wire logic [N_AXES-1:0] MOVE_DONE_I,
  input wire logic [N_AXES-1:0] MOVE_DONE_STROBE_N_O,
  input wire logic [N_AXES-1:0] MOVE_GO_O,
  input wire logic [N_AXES-1:0] HS_MODE_O,
  input wire logic [1:0]        USER_OUT_N_O
);
  // ----------------------------------------
  // x axis only, except a_ce_hold on both strobes: y is the same logic
  // ----------------------------------------
  localparam int PULSE_MAX = TICK_DIV + 4;
  localparam int ACK_MAX   = 2 * TICK_DIV + 6;
  int        uo_cnt;
  int        hi_cnt;
  wire logic stb = MOVE_DONE_STROBE_N_O[0];
  // frozen cycles do not advance the tick, so uo_cnt does not count them; hi_cnt does
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      uo_cnt <= TICK_DIV;
      hi_cnt <= 0;
    end else begin
      uo_cnt <= $changed(USER_OUT_N_O) ? 0 : uo_cnt + int'(CE_I);
      hi_cnt <= BUSY_N_I[0] ? hi_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  a_go_single:
    assert property (MOVE_GO_O[0] && CE_I |=> !MOVE_GO_O[0])
      else $error("go stands too long");
  a_strobe_done:
    assert property ($fell(stb) |-> $past(MOVE_DONE_I[0]))
      else $error("strobe without done");
  a_pulse_len:
    assert property ($fell(stb) && !HS_MODE_O[0] |->
      ##[1:PULSE_MAX] (stb || !BUSY_N_I[0])) else $error("pulse too long");
  a_hs_min_low:
    assert property ($fell(stb) && HS_MODE_O[0] |=> !stb [*3])
      else $error("strobe dropped before first sample");
  a_ack_wait:
    assert property ($rose(stb) && HS_MODE_O[0] |-> hi_cnt < ACK_MAX)
      else $error("strobe dropped without busy");
  a_mode_on:
    assert property (X_HANDSHAKE_ON_CMD_I && CE_I |-> ##[1:2] HS_MODE_O[0])
      else $error("handshake mode not taken");
  a_user_tick:
    assert property ($changed(USER_OUT_N_O) |-> uo_cnt >= TICK_DIV - 1)
      else $error("user output off tick");
  a_ce_hold:
    assert property (!CE_I |=> $stable({MOVE_DONE_STROBE_N_O, USER_OUT_N_O}))
      else $error("outputs moved while frozen");
  c_pulse: cover property ($rose(stb) && !HS_MODE_O[0]);
  c_hs:    cover property ($rose(stb) && HS_MODE_O[0]);
  c_go:    cover property (MOVE_GO_O[0]);
endmodule

bind mdh_top mdh_top_monitor #(.TICK_DIV(TICK_DIV)) mdh_top_monitor_i (
  .CLK_I(CLK_I), .RESETN_I(RESETN_I), .CE_I(CE_I), .BUSY_N_I(BUSY_N_I),
  .X_HANDSHAKE_ON_CMD_I(X_HANDSHAKE_ON_CMD_I), .MOVE_DONE_I(MOVE_DONE_I),
  .MOVE_DONE_STROBE_N_O(MOVE_DONE_STROBE_N_O), .MOVE_GO_O(MOVE_GO_O),
  .HS_MODE_O(HS_MODE_O), .USER_OUT_N_O(USER_OUT_N_O));

// >>> mdh_proc_model.sv
// partner: external machine process answering the move-done strobe
`timescale 1ns/1ps
module mdh_proc_model #(
  parameter int WORK = 30
) (
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic       strobe_n_i,
  input  wire logic [3:0] dly_i,
  output logic            busy_n_o
);
  int   cnt = 0;
  logic seen = 1'b0;
  // work spans three ticks at TD 10 so a tick-rate sampler cannot miss it;
  // outside work the line is released to its pull-up level
  assign busy_n_o = !(cnt != 0 && cnt <= WORK);
  always @(posedge clk_i) begin
    if (strobe_n_i)
      seen <= 1'b0;
    if (cnt != 0)
      cnt <= cnt - 1;
    else if (en_i && !strobe_n_i && !seen) begin
      cnt <= int'(dly_i) + WORK;
      seen <= 1'b1;
    end
  end
endmodule

// >>> tb_top.sv
// testbench: move-done handshake top with two process models
`timescale 1ns/1ps
module tb_top;
  import mdh_pkg::*;
  localparam int unsigned TD = 10;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [1:0]  req = 2'h0;
  logic [1:0]  done = 2'h0;
  logic [1:0]  hs_on = 2'h0;
  logic [1:0]  hs_off = 2'h0;
  logic [1:0]  en = 2'h0;
  logic [1:0]  uo = 2'h0;
  logic [1:0]  ui_n = 2'h3;
  logic [7:0]  dly = 8'h0;
  logic [31:0] an = 32'h0;
  logic [1:0]  busy_n, stb_n, go, mode, uo_n, ui;
  logic [31:0] an_o;
  logic [7:0]  bsy_h = 8'hff;
  logic [1:0]  exp_q[$];
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #5 clk = ~clk;

  mdh_top #(.TICK_DIV(TD), .FIRST_DLY(3)) mdh_top_i (
    .CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .BUSY_N_I(busy_n),
    .X_HANDSHAKE_ON_CMD_I(hs_on[0]), .X_HANDSHAKE_OFF_CMD_I(hs_off[0]),
    .Y_HANDSHAKE_ON_CMD_I(hs_on[1]), .Y_HANDSHAKE_OFF_CMD_I(hs_off[1]),
    .MOVE_REQ_I(req), .MOVE_DONE_I(done), .USER_OUT_I(uo),
    .USER_IN_N_I(ui_n), .ANALOG_I(an), .MOVE_DONE_STROBE_N_O(stb_n),
    .MOVE_GO_O(go), .HS_MODE_O(mode), .USER_OUT_N_O(uo_n),
    .USER_IN_O(ui), .ANALOG_O(an_o));
  mdh_proc_model mdh_proc_model_i[1:0] (.clk_i(clk), .en_i(en),
    .strobe_n_i(stb_n), .dly_i(dly), .busy_n_o(busy_n));

  task check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // 0 request, 1 done, 2 handshake on, 3 handshake off
  task pulse(input int k, input int a);
    @(posedge clk);
    case (k)
      0: req[a] <= 1'b1;
      1: done[a] <= 1'b1;
      2: hs_on[a] <= 1'b1;
      default: hs_off[a] <= 1'b1;
    endcase
    @(posedge clk);
    {req, done, hs_on, hs_off} <= 8'h0;
  endtask
  task wait_strb(input int a, input logic v);
    for (int n = 0; n < 300 && stb_n[a] !== v; n++) @(posedge clk);
    check("strobe", stb_n[a], v);
  endtask
  // axis is moving on entry; a request is pended behind the strobe
  task run_move(input int a, input bit hold);
    pulse(1, a);
    wait_strb(a, 1'b0);
    if (hold) begin
      repeat (6 * TD) @(posedge clk);
      check("no timeout", stb_n[a], 1'b0);
      en[a] <= 1'b1;
    end
    exp_q.push_back(2'h1 << a);
    pulse(0, a);
    wait_strb(a, 1'b1);
    repeat (8 * TD) @(posedge clk);
    check("pending", exp_q.size(), 0);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // busy reaches the sequencer through two flops before the tick that
  // frees the axis, so a go is judged against the pin four edges back
  always @(posedge clk) bsy_h <= {bsy_h[5:0], busy_n};
  always @(posedge clk) begin
    if (rst_n && go !== 2'h0) begin
      check("go", go, exp_q.size() ? exp_q.pop_front() : 2'h0);
      check("busy at go", bsy_h[7:6] & go, go);
    end
  end

  initial begin
    void'($urandom(32'h3f3a));
    repeat (6) @(posedge clk);
    check("reset", {stb_n, go, mode, uo_n}, 8'hc3);
    rst_n <= 1'b1;
    for (int a = 0; a < 2; a++) begin
      exp_q.push_back(2'h1 << a);
      pulse(0, a);
      for (int m = 0; m < 4; m++) begin
        en[a] <= (m == 1 || m == 2);
        dly[a*4 +: 4] <= 4'($urandom_range(15));
        pulse(m > 1 ? 2 : 3, a);
        repeat (2) @(posedge clk);
        check("mode", mode[a], m > 1);
        run_move(a, m == 3);
        $display("axis %0d mode %0d done", a, m);
      end
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      uo <= 2'($urandom);
      ui_n <= 2'($urandom);
      an <= $urandom;
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      repeat (10 * TD) @(posedge clk);
      check("user out", uo_n, 2'(~uo));
      check("user in", ui, 2'(~ui_n));
      check("analog", an_o, an);
      $display("io pass %0d done", i);
    end
    report_and_stop;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop;
  end
endmodule
